// *** bench/spi_far_slave.sv ***
// Far-side serial slave: clock idle low, sample rising, launch falling
`timescale 1ns/10ps
module spi_far_slave
(
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_miso,
    output logic [7:0]      o_rx_byte
);
    logic [7:0] shift_r;
    int         bits = 0;
    initial o_rx_byte = 8'h00;
    // No select line, so next byte's top bit waits on the line
    always @(i_tx_byte) if (bits == 0) shift_r = i_tx_byte;
    assign o_miso = shift_r[7];
    always @(posedge i_sclk)
    begin
        o_rx_byte = {o_rx_byte[6:0], i_mosi};
        bits++;
    end
    always @(negedge i_sclk)
    begin
        if (bits == 8) begin bits = 0; shift_r = i_tx_byte; end
        else shift_r = shift_r << 1;
    end
endmodule

// *** bench/spi_port_monitor.sv ***
// Checker on the serial port block's ports
`timescale 1ns/10ps
`include "spi_port_consts.vh"
module spi_port_monitor
(
    input wire logic        i_clock,
    input wire logic        i_resetn,
    input wire logic        i_hsel,
    input wire logic [7:0]  i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_irq,
    input wire logic        o_sclk,
    input wire logic        o_sclk_oe,
    input wire logic        o_mosi,
    input wire logic        o_mosi_oe,
    input wire logic        o_miso_oe,
    input wire logic        i_cs_n
);
    // ----------------------------
    // Bus phases
    // ----------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    wire req = i_hsel && i_hready && i_htrans == `HTRANS_NONSEQ;
    wire rd = req && !i_hwrite;
    // No byte can finish here, so flags hold still
    wire quiet = i_cs_n && !o_sclk_oe;
    sequence sta_rd; rd && i_haddr == `OFS_STATUS && quiet; endsequence
    sequence tx_wr; req && i_hwrite && i_haddr == `OFS_TX_HOLD; endsequence
    sequence rx_rd; rd && i_haddr == `OFS_RX_HOLD; endsequence
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready and okay");
    a_miso_dir: assert property (o_miso_oe |-> !o_mosi_oe && !o_sclk_oe && !i_cs_n)
        else $error("slave out driven wrongly");
    a_master_pins: assert property (o_mosi_oe == o_sclk_oe)
        else $error("master pins disagree");
    a_mosi_steady: assert property (o_mosi_oe && $rose(o_sclk) |-> $stable(o_mosi))
        else $error("master data moved on sample edge");
    a_rdata_idle: assert property (!rd |=> o_hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    a_irq_clear: assert property (sta_rd ##1 quiet |=> !o_irq)
        else $error("status read left irq up");
    a_tx_flag: assert property (tx_wr ##2 sta_rd |=> o_hrdata[`STA_TX_VALID])
        else $error("tx valid not set by write");
    a_rx_flag: assert property (rx_rd ##2 sta_rd |=> !o_hrdata[`STA_RX_VALID])
        else $error("rx valid not cleared by read");
endmodule
bind spi_master_slave_port spi_port_monitor u_mon (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
    .o_irq(o_irq), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .o_mosi(o_mosi),
    .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe), .i_cs_n(i_cs_n));

// *** bench/test_spi_master_slave_port.sv ***
// Self-checking bench for the serial port block
`timescale 1ns/10ps
`include "spi_port_consts.vh"
module test_spi_master_slave_port;
    logic        clk = 0, resetn = 0, hsel = 0, hwrite = 0, sclk_in = 0, mosi_in = 0, cs_n = 1;
    logic [7:0]  haddr = 0, far_tx = 0, g;
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0, q;
    wire         rdy, resp, irq, sclk, sclk_oe, mosi, mosi_oe, miso, miso_o, miso_oe;
    wire  [31:0] hrdata;
    wire  [7:0]  far_rx;
    int          err_count = 0, checks = 0, nrise = 0, base;
    time         t0;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q;} row_t;
    row_t rows [6] = '{'{`OFS_DIVIDER, 32'h0000_00A5, 32'h0000_00A5},
        '{`OFS_POWER, 32'h0000_0005, 32'h0000_0005}, '{`OFS_IRQ_MASK, 32'h0000_0029, 32'h0000_0029},
        '{8'h1C, 32'h0000_005A, 32'h0000_0000}, '{`OFS_STATUS, 32'h0000_00FF, 32'h0000_0000},
        '{`OFS_TX_HOLD, 32'h0000_007E, 32'h0000_007E}};
    always #50 clk = ~clk;
    always @(posedge sclk) nrise++;
    spi_master_slave_port DUT (.i_clock(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(rdy),
        .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrdata), .o_irq(irq), .i_sclk(sclk_in),
        .o_sclk(sclk), .o_sclk_oe(sclk_oe), .i_mosi(mosi_in), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
        .i_miso(miso), .o_miso(miso_o), .o_miso_oe(miso_oe), .i_cs_n(cs_n));
    spi_far_slave far (.i_sclk(sclk), .i_mosi(mosi), .i_tx_byte(far_tx), .o_miso(miso),
        .o_rx_byte(far_rx));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin err_count++; $display("BAD %0t got %h want %h", $time, got, exp); end
    endtask
    // Entered just after an edge; holds each phase until ready is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; htrans <= `HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        @(posedge clk); while (!rdy) @(posedge clk);
        hsel <= 0; htrans <= 2'b00; hwdata <= d;
        @(posedge clk); while (!rdy) @(posedge clk);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1, a, d); endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e); bus(0, a, 0); chk(q, e); endtask
    task automatic irqc(input logic e); @(posedge clk); chk({31'h0, irq}, {31'h0, e}); endtask
    task automatic wait_rx; q = 0; while (!q[`STA_RX_VALID]) bus(0, `OFS_STATUS, 0); endtask
    // Stands in for an external master: four core clocks or more per bit
    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge clk); mosi_in <= b[i];
            repeat (2) @(posedge clk); g[i] = miso_o; sclk_in <= 1;
            repeat (2) @(posedge clk); sclk_in <= 0;
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Whole run is a few hundred cycles; twenty thousand is ample
    initial
    begin
        #2_000_000; err_count++; tally_and_finish;
    end
    initial
    begin
        repeat (2) @(posedge clk); resetn <= 1;
        for (int i = 0; i < 7; i++) rdc(8'(i * 4), 0);
        chk({28'h0, irq, sclk_oe, mosi_oe, miso_oe}, 0);
        foreach (rows[i]) begin wr(rows[i].a, rows[i].d); rdc(rows[i].a, rows[i].q); end
        $display("test registers done");
        far_tx <= 8'h3C; wr(`OFS_DIVIDER, 1); wr(`OFS_POWER, 0); wr(`OFS_IRQ_MASK, 0);
        wr(`OFS_TX_HOLD, 32'h0000_00A5); base = nrise;
        wr(`OFS_CONTROL, 32'h0000_0003);
        @(posedge sclk); t0 = $time; repeat (7) @(posedge sclk);
        chk(32'(($time - t0) / 100), 32'h0000_001C);
        wait_rx; chk(q, 32'h0000_0008);
        chk(32'(nrise - base), 32'h0000_0008);
        rdc(`OFS_RX_HOLD, 32'h0000_003C);
        chk({24'h0, far_rx}, 32'h0000_00A5);
        for (int cd = 6; cd < 8; cd++)
        begin
            wr(`OFS_POWER, cd); wr(`OFS_TX_HOLD, 32'h0000_0011); base = nrise;
            repeat (40) @(posedge clk); chk(32'(nrise - base), 0);
            rdc(`OFS_STATUS, 32'h0000_0001);
        end
        wr(`OFS_POWER, 0); wait_rx; chk({24'h0, far_rx}, 32'h0000_0011);
        rdc(`OFS_RX_HOLD, 32'h0000_003C);
        $display("test master done");
        wr(`OFS_CONTROL, 1); wr(`OFS_IRQ_MASK, 32'h0000_0020); wr(`OFS_TX_HOLD, 32'h0000_0096);
        rdc(`OFS_STATUS, 32'h0000_0001);
        cs_n <= 0; sbyte(8'hC3); chk({24'h0, g}, 32'h0000_0096);
        chk({29'h0, miso_oe, mosi_oe, sclk_oe}, 32'h0000_0004);
        sbyte(8'h5A); chk({24'h0, g}, 0);
        @(posedge clk); cs_n <= 1; mosi_in <= ~mosi_in;
        irqc(1); chk({31'h0, miso_oe}, 0);
        wr(`OFS_IRQ_MASK, 0); irqc(0);
        wr(`OFS_IRQ_MASK, 32'h0000_0020); irqc(1);
        rdc(`OFS_STATUS, 32'h0000_0028); irqc(0);
        rdc(`OFS_RX_HOLD, 32'h0000_005A);
        rdc(`OFS_STATUS, 0);
        $display("test slave done");
        tally_and_finish;
    end
endmodule

// *** core/spi_master_slave_port.v ***
// Full-duplex byte serial port, master or slave, with AHB-Lite registers
//
// Notes on behaviour
// RULE1 - Eight bits shift out and in together, timed by the serial clock.
// RULE2 - Master mode is inert when core clock divide field is 6 or 7.
// RULE3 - Port acts as clock-making master or clock-taking slave by control bit.
// RULE4 - Transmit holding byte moves to a shift register, out on the mode's data line.
// RULE5 - Status bit 0 shows transmit holding register holds untaken data.
// RULE6 - Status bit 3 shows receive holding register holds valid data.
// RULE7 - Status bit 5 sets when received data is overwritten or discarded.
// RULE8 - Master-in/slave-out is input as master, driven output as slave.
// RULE9 - Master-out/slave-in is driven output as master, input as slave.
// RULE10 - Each unit is one byte, most significant bit first, both ways.
// RULE11 - A byte takes exactly eight serial clock periods.
// RULE12 - Serial clock is output as master, input as slave.
// RULE13 - Master clock uses control polarity/phase, rate clk over 2*(1+divider).
// RULE14 - As slave, software sets polarity and phase matching the external master.
// RULE15 - External master clock must stay at or below a quarter of core clock.
// RULE16 - Data launches on one edge, samples on the other; settings must match.
// RULE17 - Slave transfer starts on select low, bytes continue until select rises.
// RULE18 - Write sets transmit valid, load clears it; rx read clears rx valid.
`timescale 1ns/10ps
`include "spi_port_consts.vh"

module spi_master_slave_port
#(
    parameter DIV_W = 8
)
(
    input  wire        i_clock,
    input  wire        i_resetn,
    input  wire        i_hsel,
    input  wire [7:0]  i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output wire        o_hreadyout,
    output wire        o_hresp,
    output reg  [31:0] o_hrdata,
    output wire        o_irq,
    input  wire        i_sclk,
    output wire        o_sclk,
    output wire        o_sclk_oe,
    input  wire        i_mosi,
    output wire        o_mosi,
    output wire        o_mosi_oe,
    input  wire        i_miso,
    output wire        o_miso,
    output wire        o_miso_oe,
    input  wire        i_cs_n
);

// ----------------------------------------
// Bus slave
// ----------------------------------------
reg              ph_valid_r;
reg              ph_write_r;
reg  [7:0]       ph_addr_r;
reg  [3:0]       control_r;
reg  [DIV_W-1:0] divider_r;
reg  [2:0]       power_r;
reg  [7:0]       tx_holding_reg;
reg  [7:0]       rx_holding_reg;
reg              tx_valid_r;
reg              rx_valid_r;
reg              overflow_r;
reg  [7:0]       irq_pend_r;
reg  [7:0]       irq_mask_r;
wire [7:0]       port_status_reg;
wire             wr_en;
wire             rd_en;
wire             sta_rd;
wire             rx_rd;
wire             tx_wr;

assign o_hreadyout = 1'b1;
assign o_hresp     = 1'b0;
assign wr_en  = ph_valid_r & ph_write_r;
assign rd_en  = ph_valid_r & ~ph_write_r;
assign tx_wr  = wr_en & (ph_addr_r == `OFS_TX_HOLD);
assign rx_rd  = rd_en & (ph_addr_r == `OFS_RX_HOLD);
assign sta_rd = rd_en & (ph_addr_r == `OFS_STATUS);

always @(posedge i_clock)
begin
    if (!i_resetn)
    begin
        ph_valid_r <= 1'b0;
        ph_write_r <= 1'b0;
        ph_addr_r  <= 8'h00;
    end
    else if (i_hready)
    begin
        ph_valid_r <= i_hsel & (i_htrans == `HTRANS_NONSEQ);
        ph_write_r <= i_hwrite;
        ph_addr_r  <= i_haddr;
    end
end

// Read data is combinational on the data phase, but drawn from registers
always @*
begin
    o_hrdata = 32'h0000_0000;
    if (rd_en)
    begin
        case (ph_addr_r)
            `OFS_TX_HOLD:  o_hrdata[7:0] = tx_holding_reg;
            `OFS_RX_HOLD:  o_hrdata[7:0] = rx_holding_reg;
            `OFS_STATUS:   o_hrdata[7:0] = port_status_reg;
            `OFS_CONTROL:  o_hrdata[3:0] = control_r;
            `OFS_DIVIDER:  o_hrdata[DIV_W-1:0] = divider_r;
            `OFS_POWER:    o_hrdata[2:0] = power_r;
            `OFS_IRQ_MASK: o_hrdata[7:0] = irq_mask_r;
            default:       o_hrdata = 32'h0000_0000;
        endcase
    end
end

always @(posedge i_clock)
begin
    if (!i_resetn)
    begin
        control_r  <= `CONTROL_RESET;
        divider_r  <= {DIV_W{1'b0}};
        power_r    <= `POWER_RESET;
        irq_mask_r <= 8'h00;
    end
    else if (wr_en)
    begin
        if (ph_addr_r == `OFS_CONTROL)
            control_r <= i_hwdata[3:0];
        if (ph_addr_r == `OFS_DIVIDER)
            divider_r <= i_hwdata[DIV_W-1:0];
        if (ph_addr_r == `OFS_POWER)
            power_r <= i_hwdata[2:0];
        if (ph_addr_r == `OFS_IRQ_MASK)
            irq_mask_r <= i_hwdata[7:0];
    end
end

// ----------------------------------------
// Mode decode
// ----------------------------------------
wire en       = control_r[`CON_ENABLE];
wire is_mst   = control_r[`CON_MASTER];                               // [RULE3]
wire cpol     = control_r[`CON_CPOL];
wire cpha     = control_r[`CON_CPHA];
wire cd_bad   = (power_r == `CD_BAD_LO) | (power_r == `CD_BAD_HI);
wire mst_run  = en & is_mst & ~cd_bad;                                 // [RULE2]
wire slv_run  = en & ~is_mst;

// ----------------------------------------
// Master clock divider
// ----------------------------------------
// Half period is (1+divider) core cycles, so full rate is clk/(2*(1+div))
reg  [DIV_W-1:0] div_cnt_r;
reg              m_busy_r;
reg              m_sclk_r;
reg  [3:0]       m_edge_r;
wire             half_tick = m_busy_r & (div_cnt_r == divider_r);      // [RULE13]

always @(posedge i_clock)
begin
    if (!i_resetn || !m_busy_r)
        div_cnt_r <= {DIV_W{1'b0}};
    else if (half_tick)
        div_cnt_r <= {DIV_W{1'b0}};
    else
        div_cnt_r <= div_cnt_r + 1'b1;
end

// ----------------------------------------
// Slave clock and select edge detect
// ----------------------------------------
// Pins are taken as synchronous; one register gives edge history
reg  s_sclk_q_r;
reg  s_cs_q_r;
wire s_rise = i_sclk & ~s_sclk_q_r;
wire s_fall = ~i_sclk & s_sclk_q_r;
wire s_sel  = slv_run & ~i_cs_n;                                       // [RULE17]

always @(posedge i_clock)
begin
    if (!i_resetn)
    begin
        s_sclk_q_r <= 1'b0;
        s_cs_q_r   <= 1'b1;
    end
    else
    begin
        s_sclk_q_r <= i_sclk;
        s_cs_q_r   <= i_cs_n;
    end
end

// Leading edge is away from idle level, trailing edge back to it
wire lead_s  = cpol ? s_fall : s_rise;
wire trail_s = cpol ? s_rise : s_fall;
wire s_start = s_sel & s_cs_q_r;

// Master: odd half ticks are leading edges, even are trailing
wire m_lead  = half_tick & ~m_edge_r[0];
wire m_trail = half_tick &  m_edge_r[0];

// Sample on one edge, launch on the other                              [RULE16]
wire samp    = is_mst ? (cpha ? m_trail : m_lead) : (s_sel & (cpha ? trail_s : lead_s));
wire launch  = is_mst ? (cpha ? m_lead : m_trail) : (s_sel & (cpha ? lead_s : trail_s));

// ----------------------------------------
// Shift engine
// ----------------------------------------
reg  [7:0] tx_shift_r;
reg  [7:0] rx_shift_r;
reg  [3:0] bit_cnt_r;
reg        rx_full_r;
// Marks the first launch edge after select; the byte is already loaded
reg        s_first_r;
wire       byte_done = samp & (bit_cnt_r == `BITS_PER_BYTE - 4'h1);    // [RULE11]
wire       m_start   = mst_run & ~m_busy_r & tx_valid_r;
// Next byte loads on the launch edge after a byte, so its top bit is not shifted away
wire       s_load    = s_start | (s_sel & launch & (bit_cnt_r == 4'h0) & ~s_first_r);
wire       tx_take   = tx_valid_r & (m_start | s_load);
wire       rx_ovr;

always @(posedge i_clock)
begin
    if (!i_resetn)
    begin
        tx_shift_r <= 8'h00;
        rx_shift_r <= 8'h00;
        bit_cnt_r  <= 4'h0;
        m_busy_r   <= 1'b0;
        m_sclk_r   <= 1'b0;
        m_edge_r   <= 4'h0;
        rx_full_r  <= 1'b0;
        s_first_r  <= 1'b0;
    end
    else
    begin
        rx_full_r <= 1'b0;
        if (s_start)
            s_first_r <= 1'b1;
        else if (launch)
            s_first_r <= 1'b0;
        if (m_start | s_start)
        begin
            // Load holding byte, or zero when nothing written    [RULE4]
            tx_shift_r <= tx_valid_r ? tx_holding_reg : 8'h00;
            bit_cnt_r  <= 4'h0;
            m_busy_r   <= m_start;
            m_sclk_r   <= cpol;
            m_edge_r   <= 4'h0;
        end
        else
        begin
            if (!s_sel && !is_mst)
                bit_cnt_r <= 4'h0;
            if (half_tick)
            begin
                m_sclk_r <= ~m_sclk_r;
                m_edge_r <= m_edge_r + 4'h1;
                // Stop after sixteen half periods                   [RULE11]
                if (m_edge_r == 4'hF)
                begin
                    m_busy_r <= 1'b0;
                    m_sclk_r <= cpol;
                end
            end
            if (samp)
            begin
                rx_shift_r <= {rx_shift_r[6:0], is_mst ? i_miso : i_mosi}; // [RULE10]
                bit_cnt_r  <= byte_done ? 4'h0 : bit_cnt_r + 4'h1;         // [RULE1]
                rx_full_r  <= byte_done;
            end
            if (launch && !(bit_cnt_r == 4'h0 && (s_sel ? s_first_r : cpha)))
                tx_shift_r <= {tx_shift_r[6:0], 1'b0};                     // [RULE10]
            if (s_load && !s_start)
                tx_shift_r <= tx_valid_r ? tx_holding_reg : 8'h00;         // [RULE4]
        end
        if (!mst_run && is_mst)
            m_busy_r <= 1'b0;
    end
end

// ----------------------------------------
// Holding registers and status
// ----------------------------------------
wire [7:0] rx_word = rx_shift_r;
assign rx_ovr = rx_full_r & rx_valid_r & ~rx_rd;

always @(posedge i_clock)
begin
    if (!i_resetn)
    begin
        tx_holding_reg <= 8'h00;
        rx_holding_reg <= 8'h00;
        tx_valid_r     <= 1'b0;
        rx_valid_r     <= 1'b0;
        overflow_r     <= 1'b0;
    end
    else
    begin
        if (tx_wr)
        begin
            tx_holding_reg <= i_hwdata[7:0];
            tx_valid_r     <= 1'b1;                                    // [RULE18]
        end
        else if (tx_take)
            tx_valid_r <= 1'b0;                                        // [RULE18]
        if (rx_full_r)
        begin
            rx_holding_reg <= rx_word;
            rx_valid_r     <= 1'b1;                                    // [RULE6]
        end
        else if (rx_rd)
            rx_valid_r <= 1'b0;                                        // [RULE18]
        // Overwrite of unread byte; set wins over a status read clear
        if (rx_ovr)
            overflow_r <= 1'b1;                                        // [RULE7]
        else if (sta_rd)
            overflow_r <= 1'b0;
    end
end

assign port_status_reg = {2'b00, overflow_r, 1'b0, rx_valid_r, 2'b00, tx_valid_r}; // [RULE5]

// ----------------------------------------
// Interrupts
// ----------------------------------------
// Events: tx taken, rx byte arrived, overflow; cleared by a status read
wire [7:0] irq_evt = {2'b00, rx_ovr, 1'b0, rx_full_r, 2'b00, tx_take};

always @(posedge i_clock)
begin
    if (!i_resetn)
        irq_pend_r <= 8'h00;
    else
        irq_pend_r <= (sta_rd ? 8'h00 : irq_pend_r) | irq_evt;
end

assign o_irq = |(irq_pend_r & irq_mask_r);

// ----------------------------------------
// Pins
// ----------------------------------------
assign o_sclk    = m_busy_r ? m_sclk_r : cpol;
assign o_sclk_oe = en & is_mst;                                        // [RULE12]
assign o_mosi    = tx_shift_r[7];
assign o_mosi_oe = en & is_mst;                                        // [RULE9]
assign o_miso    = tx_shift_r[7];
assign o_miso_oe = slv_run & ~i_cs_n;                                  // [RULE8]

endmodule

// *** core/spi_port_consts.vh ***
// Constants for the serial port block: offsets, fields, reset values
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_TX_HOLD     8'h00
`define OFS_RX_HOLD     8'h04
`define OFS_STATUS      8'h08
`define OFS_CONTROL     8'h0C
`define OFS_DIVIDER     8'h10
`define OFS_POWER       8'h14
`define OFS_IRQ_MASK    8'h18

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define STA_TX_VALID    0
`define STA_RX_VALID    3
`define STA_OVERFLOW    5

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define CON_ENABLE      0
`define CON_MASTER      1
`define CON_CPOL        2
`define CON_CPHA        3

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CONTROL_RESET   4'h0
`define DIVIDER_RESET   8'h00
`define POWER_RESET     3'h0
`define CD_BAD_LO       3'h6
`define CD_BAD_HI       3'h7
`define BITS_PER_BYTE   4'h8
`define HTRANS_NONSEQ   2'b10

`endif
